// *** obim_gate.sv ***
// Per-line gate: registered OR of unmasked status bits.
// Assumes status and mask come from the same clock domain.
`timescale 1ns/100ps
`default_nettype none
module obim_gate #(
  parameter int N = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Sources
  input wire logic [N-1:0] srcState,
  input wire logic [N-1:0] srcMask,
  // Gated output
  output logic irqOut
);

  // ==========================================================================
  // Output flop: one clock behind any status or mask change
  // registered OR gate
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= |(srcState & ~srcMask);
    end
  end

endmodule
`default_nettype wire

// *** obim_mask.sv ***
// Outbound interrupt mask block: mask register, recorded interrupt state,
// ring register software bits and the gating onto the PCI interrupt lines.
// Assumes a simple synchronous local bus (sel/wr/addr) and a PCI-side clear
// port for the ring bits, all on sys_clk.
//
// Functional notes
// - each mask bit pairs one state bit
// - mask one blocks, zero allows interrupt
// - mask writes never alter interrupt state
// - mask bits 7..4 gate lines D..A
// - mask bit 2 gates ring interrupt
// - mask bit 1 gates message 1
// - mask bit 0 gates message 0
// - ring state while any software bit set
// - message write sets; clear removes interrupt
// - lines own pins; others shared pin
// - local sets, PCI clears software bits
`timescale 1ns/100ps
`default_nettype none
module obim_mask
  import obim_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Local bus register port
  input wire logic lbSel,
  input wire logic lbWr,
  input wire logic [15:0] lbAddr,
  input wire logic [31:0] lbWdata,
  output logic [31:0] lbRdata_ff,
  // Messaging unit events
  input wire logic msg0Write,
  input wire logic msg1Write,
  input wire logic msg0Clear,
  input wire logic msg1Clear,
  // PCI side clear of ring bits (write one to clear)
  input wire logic pciRingClr,
  input wire logic [31:0] pciRingClrData,
  // Shared pin choice
  input wire obim_pin_t pinSelect,
  // PCI interrupt lines, active high request (A..D)
  output logic [3:0] pciIrq
);

  // Mask register, low byte only is implemented
  logic [7:0] mask_ff;
  // Message interrupt state bits
  logic msg0_ff;
  logic msg1_ff;
  // Ring register software and line bits
  logic [OBIM_SWI_W-1:0] swi_ff;
  logic [3:0] ringLine_ff;
  // Assembled state byte
  logic [7:0] state;
  // Gated outputs
  logic [3:0] lineIrq;
  logic sharedIrq;
  // Shared pin raise, one flop deep
  logic [3:0] sharedVec_ff;
  logic maskWr;
  logic ringWr;

  assign maskWr = lbSel && lbWr && (lbAddr == OBIM_MASK_OFFSET);
  assign ringWr = lbSel && lbWr && (lbAddr == OBIM_RING_OFFSET);

  // ==========================================================================
  // Mask register
  // one bit per source
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_ff <= OBIM_MASK_RESET[7:0];
    end else if (maskWr) begin
      // Reserved bits stay zero
      mask_ff <= lbWdata[7:0] & OBIM_MASK_WMASK;
    end
  end

  // ==========================================================================
  // Message state: set wins over clear so no event is lost
  // write sets, clear removes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      msg0_ff <= 1'b0;
      msg1_ff <= 1'b0;
    end else begin
      msg0_ff <= msg0Write | (msg0_ff & ~msg0Clear);
      msg1_ff <= msg1Write | (msg1_ff & ~msg1Clear);
    end
  end

  // ==========================================================================
  // Ring software bits: local bus only sets, PCI side only clears
  // split set and clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      swi_ff <= OBIM_SWI_ZERO;
      ringLine_ff <= OBIM_LINE_ZERO;
    end else begin
      // Local writes of zero are ignored; a same-cycle set beats the clear
      swi_ff <= (swi_ff & ~(pciRingClr ? pciRingClrData[OBIM_SWI_W-1:0] : OBIM_SWI_ZERO))
        | (ringWr ? lbWdata[OBIM_SWI_W-1:0] : OBIM_SWI_ZERO);
      // Line bits are plain local-bus read/write
      if (ringWr) begin
        ringLine_ff <= lbWdata[OBIM_RING_LINE_LO +: OBIM_LINE_CNT];
      end
    end
  end

  // ==========================================================================
  // State assembly, independent of the mask
  always_comb begin
    state = 8'h00;
    state[OBIM_MSG0_BIT] = msg0_ff;
    state[OBIM_MSG1_BIT] = msg1_ff;
    state[OBIM_RING_BIT] = |swi_ff;
    state[OBIM_LINE_LO +: OBIM_LINE_CNT] = ringLine_ff;
  end

  // ==========================================================================
  // Individually routed lines, one gate per line
  // bits 7..4 gate D..A
  genvar gi;
  generate
    for (gi = 0; gi < OBIM_LINE_CNT; gi++) begin : g_line
      obim_gate #(.N(1)) u_gate (
        .sys_clk(sys_clk),
        .rst(rst),
        .srcState(state[OBIM_LINE_LO + gi]),
        .srcMask(mask_ff[OBIM_LINE_LO + gi]),
        .irqOut(lineIrq[gi])
      );
    end
  endgenerate

  // Shared source: ring and both messages
  // bit 2 gates ring
  assign sharedIrq = |(state[OBIM_RING_BIT:OBIM_MSG0_BIT] & ~mask_ff[OBIM_RING_BIT:OBIM_MSG0_BIT]);

  // ==========================================================================
  // Shared pin steering, same latency as the line gates
  // shared pin by selector
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sharedVec_ff <= 4'h0;
    end else begin
      sharedVec_ff <= sharedIrq ? (4'h1 << pinSelect) : 4'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pciIrq <= 4'h0;
    end else begin
      pciIrq <= lineIrq | sharedVec_ff;
    end
  end

  // ==========================================================================
  // Register readback, one cycle after the address; unmapped reads zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lbRdata_ff <= 32'h00000000;
    end else if (lbSel && !lbWr) begin
      unique case (lbAddr)
        OBIM_MASK_OFFSET: lbRdata_ff <= {24'h000000, mask_ff};
        OBIM_STATE_OFFSET: lbRdata_ff <= {24'h000000, state};
        OBIM_RING_OFFSET: lbRdata_ff <= {ringLine_ff, swi_ff};
        default: lbRdata_ff <= 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  a_mask_blocks_line:
  assert property (@(posedge sys_clk) disable iff (rst)
    (mask_ff[OBIM_LINE_LO] && $past(mask_ff[OBIM_LINE_LO]) && $past(mask_ff[OBIM_LINE_LO], 2)
     && !sharedIrq && !$past(sharedIrq)) |-> ##1 !pciIrq[0])
    else $error("line A raised while masked");
  a_mask_keeps_state:
  assert property (@(posedge sys_clk) disable iff (rst)
    (maskWr && !msg0Write && !msg0Clear) |=> (msg0_ff == $past(msg0_ff)))
    else $error("mask write changed message state");
  a_ring_state_any:
  assert property (@(posedge sys_clk) disable iff (rst)
    (ringWr && (lbWdata[OBIM_SWI_W-1:0] != OBIM_SWI_ZERO)) |=> state[OBIM_RING_BIT])
    else $error("ring write did not raise ring state");
  a_msg_set_wins:
  assert property (@(posedge sys_clk) disable iff (rst)
    msg1Write |=> msg1_ff)
    else $error("message 1 write lost");
  a_local_no_clear:
  assert property (@(posedge sys_clk) disable iff (rst)
    (!pciRingClr) |=> ((swi_ff & $past(swi_ff)) == $past(swi_ff)))
    else $error("software bit cleared by local side");
  a_shared_route:
  assert property (@(posedge sys_clk) disable iff (rst)
    (sharedIrq && !rst) |=> ##1 pciIrq[$past(pinSelect, 2)])
    else $error("shared interrupt not on selected pin");
  a_msg0_gated:
  assert property (@(posedge sys_clk) disable iff (rst)
    (msg0_ff && !mask_ff[OBIM_MSG0_BIT]) |-> ##2 (|pciIrq))
    else $error("unmasked message 0 not raised");
  a_line_unmasked:
  assert property (@(posedge sys_clk) disable iff (rst)
    (ringLine_ff[3] && !mask_ff[7]) |-> ##2 pciIrq[3])
    else $error("unmasked line D not raised");

endmodule
`default_nettype wire

// *** obim_mask_test.sv ***
// Self-checking bench for obim_mask: mask, message, ring and line cases.
// Assumes obim_pci_host on the PCI side and one 40 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module obim_mask_test;
  import obim_pkg::*;
  // ==========================================================================
  // Stimulus and observed signals
  localparam logic [15:0] MK = OBIM_MASK_OFFSET;
  localparam logic [15:0] ST = OBIM_STATE_OFFSET;
  localparam logic [15:0] RG = OBIM_RING_OFFSET;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic lbSel = 1'b0;
  logic lbWr = 1'b0;
  logic [15:0] lbAddr = 16'h0;
  logic [31:0] lbWdata = 32'h0;
  logic [31:0] lbRdata_ff;
  logic [3:0] evt = 4'h0; // Message clears and writes: {c1, c0, w1, w0}
  logic pciRingClr;
  logic [31:0] pciRingClrData;
  obim_pin_t pinSelect = 2'h0;
  logic [3:0] pciIrq;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  always #12.5 sys_clk = ~sys_clk;
  obim_mask u_dut (.sys_clk(sys_clk), .rst(rst), .lbSel(lbSel), .lbWr(lbWr),
    .lbAddr(lbAddr), .lbWdata(lbWdata), .lbRdata_ff(lbRdata_ff), .msg0Write(evt[0]),
    .msg1Write(evt[1]), .msg0Clear(evt[2]), .msg1Clear(evt[3]), .pciRingClr(pciRingClr),
    .pciRingClrData(pciRingClrData), .pinSelect(pinSelect), .pciIrq(pciIrq));
  obim_pci_host u_host (.sys_clk(sys_clk), .pciIrq(pciIrq), .pciRingClr(pciRingClr),
    .pciRingClrData(pciRingClrData));
  // ==========================================================================
  // Compare, verdict and hang guard
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Run is about two hundred cycles; the ceiling at 2000 leaves a tenfold margin
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      give_verdict();
    end
  end
  // ==========================================================================
  // Bus and event tasks, all entered just after a rising edge
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    lbSel = 1'b1;
    lbWr = 1'b1;
    lbAddr = a;
    lbWdata = d;
    @(posedge sys_clk);
    #2;
    lbSel = 1'b0;
    lbWr = 1'b0;
    // One idle edge so a following access never re-raises the select in this step
    @(posedge sys_clk);
    #2;
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    lbSel = 1'b1;
    lbAddr = a;
    @(posedge sys_clk);
    #2;
    lbSel = 1'b0;
    check(lbRdata_ff, exp);
    @(posedge sys_clk);
    #2;
  endtask
  task automatic ev(input logic [3:0] v);
    evt = v;
    @(posedge sys_clk);
    #2;
    evt = 4'h0;
    @(posedge sys_clk);
    #2;
  endtask
  // Lines settle within three edges of a change; four are allowed
  task automatic irq(input logic [3:0] exp);
    repeat (4) @(posedge sys_clk);
    #2;
    check({28'h0, u_host.pciIrq}, {28'h0, exp});
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_mask();
    wr(MK, 32'hFFFFFFFF);
    rd(MK, {24'h0, OBIM_MASK_WMASK});
    rd(16'h1338, 32'h0);
    wr(MK, 32'h0);
  endtask
  task automatic t_msgs();
    for (int k = 0; k < 2; k++) begin
      pinSelect = obim_pin_t'(k + 2);
      ev(4'h1 << k);
      irq(4'h1 << (k + 2));
      wr(MK, 32'h1 << k);
      irq(4'h0);
      rd(ST, 32'h1 << k);
      wr(MK, ~(32'h1 << k));
      irq(4'h1 << (k + 2));
      wr(MK, 32'h0);
      ev(4'h4 << k);
      irq(4'h0);
    end
  endtask
  task automatic t_ring();
    pinSelect = 2'h1;
    wr(RG, 32'h5);
    irq(4'h2);
    wr(MK, 32'h4);
    irq(4'h0);
    rd(ST, 32'h4);
    wr(MK, 32'h0);
    wr(RG, 32'h0);
    rd(RG, 32'h5);
    u_host.clear_bits(28'h1);
    irq(4'h2);
    u_host.clear_bits(28'h4);
    irq(4'h0);
    rd(ST, 32'h0);
  endtask
  task automatic t_lines();
    for (int i = 0; i < 4; i++) begin
      wr(RG, 32'h1 << (28 + i));
      irq(4'h1 << i);
      wr(MK, 32'h10 << i);
      irq(4'h0);
      rd(ST, 32'h10 << i);
      wr(MK, ~(32'h10 << i));
      irq(4'h1 << i);
      wr(MK, 32'h0);
    end
  endtask
  // ==========================================================================
  // Main sequence: reset for eight cycles, then each scenario
  initial begin
    repeat (8) @(posedge sys_clk);
    #2;
    rst = 1'b0;
    rd(MK, OBIM_MASK_RESET);
    irq(4'h0);
    t_mask();
    t_msgs();
    t_ring();
    t_lines();
    give_verdict();
  end
endmodule
`default_nettype wire

// *** obim_pci_host.sv ***
// PCI host stand-in for the outbound interrupt block: sees the interrupt
// lines and clears ring software bits. Assumes it shares sys_clk.
`timescale 1ns/100ps
`default_nettype none
module obim_pci_host (
  // Clock
  input wire logic sys_clk,
  // Interrupt lines seen by the host
  input wire logic [3:0] pciIrq,
  // Write-one-to-clear toward the block
  output logic pciRingClr,
  output logic [31:0] pciRingClrData
);
  // ==========================================================================
  // Idle: no clear; data bus starts at zero, then keeps the inverted last clear value
  initial pciRingClr = 1'b0;
  initial pciRingClrData = 32'h0;
  task automatic clear_bits(input logic [27:0] bits);
    @(posedge sys_clk);
    #2;
    pciRingClr = 1'b1;
    pciRingClrData = {4'h0, bits};
    @(posedge sys_clk);
    #2;
    pciRingClr = 1'b0;
    // Released data is scrambled so a stale value is never relied on
    pciRingClrData = ~pciRingClrData;
  endtask
endmodule
`default_nettype wire

// *** obim_pkg.sv ***
// Package for the outbound interrupt mask block: register offsets, field
// positions, reset values and the interrupt pin selector encoding.
// Assumes a 32-bit local bus word and four individually routed PCI lines.
package obim_pkg;

  // ==========================================================================
  // Register map
  localparam logic [15:0] OBIM_MASK_OFFSET = 16'h1334;
  localparam logic [15:0] OBIM_STATE_OFFSET = 16'h1330;
  localparam logic [15:0] OBIM_RING_OFFSET = 16'h132C;
  localparam logic [31:0] OBIM_MASK_RESET = 32'h00000000;
  // Writable mask bits: 7..4, 2..0; bit 3 and 31..8 reserved
  localparam logic [7:0] OBIM_MASK_WMASK = 8'hF7;

  // ==========================================================================
  // Field positions shared by mask and state
  localparam int OBIM_MSG0_BIT = 0;
  localparam int OBIM_MSG1_BIT = 1;
  localparam int OBIM_RING_BIT = 2;
  localparam int OBIM_LINE_LO = 4;
  localparam int OBIM_LINE_CNT = 4;
  // Ring register: software interrupt bits 27..0, line request bits 31..28
  localparam int OBIM_SWI_W = 28;
  localparam int OBIM_RING_LINE_LO = 28;
  localparam logic [OBIM_SWI_W-1:0] OBIM_SWI_ZERO = 28'h0000000;
  localparam logic [3:0] OBIM_LINE_ZERO = 4'h0;

  // Selector for the shared interrupt pin (0..3 = A..D)
  typedef logic [1:0] obim_pin_t;

endpackage
